//--- verilog/scsi_ctl_map.svh
// Constants for the SCSI host control and event queue handler
// Functional notes
// - Every control command gets a response byte from the common code set.
// - Leading type word selects layout: 0 task mgmt, 1 query, 2 subscribe.
// - Task management subtype selects one of eight functions, codes 0 to 7.
// - Task management outcome uses complete 0, succeeded 10, rejected 11.
// - Irrelevant fields ignored; LUN bytes ignored for whole nexus functions.
// - Task-specific functions match the 64-bit command identifier; only abort task does, query task is answered complete 0 without a match.
// - Unit or nexus reset completes every active command with reset code.
// - Abort task or task set completes selected commands with aborted code.
// - Completions caused by a function are visible before its own completion.
// - Query writes supported events from the six mask bits into actual word.
// - Subscription records the mask per LUN and returns the supported subset.
// - Legacy mode lays out control structures in guest native byte order.
// - Events not queued; dropped when no buffer is available.
// - Event word bit 31 set whenever events were lost for missing buffers.
// - A too-short event buffer may be returned at once with code 0.
// - After drops, a no-event report with missed flag prompts the driver.
// - Transport reset uses code 1, reasons hard 0, rescan 1, removed 2.
// - Removed or rescan reports only when hot-plug was negotiated.
// - Transport resets also reported as sense data with fixed key and codes.
// - Asynchronous notification uses code 2, reason limited to subscribed events.
// - Parameter change uses code 3, asc in bits 7:0, ascq in 15:8.
// - Never send parameter change for units of inquiry device type 5.
`ifndef SCSI_CTL_MAP_SVH
`define SCSI_CTL_MAP_SVH

`define RESP_OK            8'h00
`define RESP_ABORTED       8'h02
`define RESP_BAD_TARGET    8'h03
`define RESP_RESET         8'h04
`define RESP_BUSY          8'h05
`define RESP_FAILURE       8'h09
`define RESP_FUNC_COMPLETE 8'h00
`define RESP_FUNC_SUCCEED  8'h0a
`define RESP_FUNC_REJECT   8'h0b
`define RESP_INCORRECT_LUN 8'h0c
`define EVT_SUPPORTED      32'h0000_007e
`define EVT_MISSED_BIT     31
`define REASON_HARD        32'h0000_0000
`define REASON_RESCAN      32'h0000_0001
`define REASON_REMOVED     32'h0000_0002
`define SENSE_ILLEGAL_REQ  4'h5
`define SENSE_UNIT_ATTN    4'h6
`define ASC_REMOVED        8'h25
`define ASC_HARD           8'h29
`define ASC_RESCAN         8'h3f
`define ASCQ_RESCAN        8'h0e
`define ASCQ_ZERO          8'h00
`define MMC_DEV_TYPE       5'h05
`define NUM_LUNS           4
`define LUN_SEL_W          2

`endif

//--- verilog/scsi_ctl_pkg.sv
// Types for the SCSI host control and event queue handler
package scsi_ctl_pkg;
    typedef enum logic [31:0] {
        CTRL_TMF          = 32'h0000_0000,
        CTRL_AN_QUERY     = 32'h0000_0001,
        CTRL_AN_SUBSCRIBE = 32'h0000_0002
    } ctrl_type_t;
    typedef enum logic [31:0] {
        TMF_ABORT_TASK     = 32'h0000_0000,
        TMF_ABORT_TASK_SET = 32'h0000_0001,
        TMF_CLEAR_ACA      = 32'h0000_0002,
        TMF_CLEAR_TASK_SET = 32'h0000_0003,
        TMF_IT_NEXUS_RESET = 32'h0000_0004,
        TMF_LU_RESET       = 32'h0000_0005,
        TMF_QUERY_TASK     = 32'h0000_0006,
        TMF_QUERY_TASK_SET = 32'h0000_0007
    } tmf_subtype_t;
    typedef enum logic [31:0] {
        EV_NO_EVENT     = 32'h0000_0000,
        EV_TRANSPORT    = 32'h0000_0001,
        EV_ASYNC_NOTIFY = 32'h0000_0002,
        EV_PARAM_CHANGE = 32'h0000_0003
    } event_code_t;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_KILL   = 2'b01,
        ST_FENCE  = 2'b10,
        ST_FINISH = 2'b11
    } ctrl_state_t;
endpackage

//--- verilog/byte_order.sv
// Word swapper choosing little-endian or guest native order
`timescale 1ns/1ps
module byte_order #(
    parameter int W = 32
) (
    input  wire logic         big_endian,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] swapped;
    always_comb begin
        swapped = '0;
        for (int i = 0; i < W / 8; i++) begin
            swapped[8*i +: 8] = din[W-8-8*i +: 8];
        end
        dout = big_endian ? swapped : din;
    end
endmodule

//--- verilog/scsi_ctl_event.sv
// Control queue decoder and event queue writer of the SCSI host device
`timescale 1ns/1ps
`include "scsi_ctl_map.svh"
module scsi_ctl_event (
    input  wire logic                     ref_clk,
    input  wire logic                     nrst,
    input  wire logic                     legacy_mode,
    input  wire logic                     guest_big_endian,
    input  wire logic                     hotplug_negotiated,
    input  wire logic                     ctrl_valid,
    output logic                          ctrl_ready,
    input  wire logic [31:0]              ctrl_type_raw,
    input  wire logic [31:0]              ctrl_subtype_raw,
    input  wire logic [63:0]              ctrl_lun,
    input  wire logic [63:0]              ctrl_id_raw,
    input  wire logic [31:0]              ctrl_event_req_raw,
    output logic                          ctrl_done,
    output logic [7:0]                    ctrl_response,
    output logic [31:0]                   ctrl_event_actual,
    input  wire logic                     target_present,
    input  wire logic                     lun_present,
    input  wire logic                     target_busy,
    output logic                          kill_req,
    output logic                          kill_all,
    output logic                          kill_target_only,
    output logic [63:0]                   kill_id,
    output logic [7:0]                    kill_code,
    input  wire logic                     kill_ack,
    input  wire logic                     kill_found,
    output logic                          fence_req,
    input  wire logic                     fence_ack,
    input  wire logic                     evt_req,
    input  wire scsi_ctl_pkg::event_code_t evt_code,
    input  wire logic [63:0]              evt_lun,
    input  wire logic [31:0]              evt_reason,
    input  wire logic [4:0]               evt_dev_type,
    output logic                          evt_taken,
    input  wire logic                     evt_buf_avail,
    input  wire logic                     evt_buf_short,
    output logic                          evt_write,
    output logic [31:0]                   evt_word,
    output logic [63:0]                   evt_lun_out,
    output logic [31:0]                   evt_reason_out,
    output logic                          sense_valid,
    output logic [3:0]                    sense_key,
    output logic [7:0]                    sense_asc,
    output logic [7:0]                    sense_ascq
);
    import scsi_ctl_pkg::*;

    // ------------------------------------------------------------
    // Byte order of control fields
    // ------------------------------------------------------------
    logic        swap;
    logic [31:0] ctrl_type_w;
    logic [31:0] ctrl_subtype_w;
    logic [31:0] ctrl_event_req_w;
    logic [31:0] id_lo;
    logic [31:0] id_hi;
    logic [31:0] actual_le;
    logic [31:0] next_actual;
    logic [63:0] ctrl_id;

    assign swap = legacy_mode & guest_big_endian;
    byte_order #(.W(32)) u_type    (.big_endian(swap), .din(ctrl_type_raw),      .dout(ctrl_type_w));
    byte_order #(.W(32)) u_subtype (.big_endian(swap), .din(ctrl_subtype_raw),   .dout(ctrl_subtype_w));
    byte_order #(.W(32)) u_evreq   (.big_endian(swap), .din(ctrl_event_req_raw), .dout(ctrl_event_req_w));
    byte_order #(.W(32)) u_idlo    (.big_endian(swap), .din(ctrl_id_raw[31:0]),  .dout(id_lo));
    byte_order #(.W(32)) u_idhi    (.big_endian(swap), .din(ctrl_id_raw[63:32]), .dout(id_hi));
    byte_order #(.W(32)) u_actual  (.big_endian(swap), .din(next_actual),        .dout(actual_le));
    assign ctrl_id = swap ? {id_lo, id_hi} : {id_hi, id_lo};

    // ------------------------------------------------------------
    // Control request decode
    // ------------------------------------------------------------
    ctrl_state_t                 state;
    logic [`NUM_LUNS-1:0][31:0]  subscribed;
    logic [`LUN_SEL_W-1:0]       ctrl_lun_sel;
    logic [`LUN_SEL_W-1:0]       evt_lun_sel;
    logic                        is_nexus;
    logic                        needs_kill;
    logic                        lun_ok;
    logic [7:0]                  next_resp;
    logic [7:0]                  pending_resp;
    logic                        take;

    assign ctrl_lun_sel = ctrl_lun[16 +: `LUN_SEL_W];
    assign evt_lun_sel  = evt_lun[16 +: `LUN_SEL_W];
    assign ctrl_ready   = (state == ST_IDLE);
    assign take         = ctrl_valid & ctrl_ready;
    assign is_nexus     = (ctrl_subtype_w == TMF_IT_NEXUS_RESET);
    assign lun_ok       = is_nexus | lun_present;

    always_comb begin
        next_resp   = `RESP_OK;
        next_actual = 32'h0000_0000;
        needs_kill  = 1'b0;
        case (ctrl_type_w)
            CTRL_TMF: begin
                if (!target_present) begin
                    next_resp = `RESP_BAD_TARGET;
                end else if (!lun_ok) begin
                    next_resp = `RESP_INCORRECT_LUN;
                end else if (target_busy) begin
                    next_resp = `RESP_BUSY;
                end else begin
                    case (ctrl_subtype_w)
                        TMF_ABORT_TASK, TMF_ABORT_TASK_SET,
                        TMF_IT_NEXUS_RESET, TMF_LU_RESET: begin
                            needs_kill = 1'b1;
                            next_resp  = `RESP_FUNC_COMPLETE;
                        end
                        TMF_CLEAR_ACA, TMF_CLEAR_TASK_SET: begin
                            next_resp = `RESP_FUNC_COMPLETE;
                        end
                        TMF_QUERY_TASK, TMF_QUERY_TASK_SET: begin
                            next_resp = `RESP_FUNC_COMPLETE;
                        end
                        default: begin
                            next_resp = `RESP_FUNC_REJECT;
                        end
                    endcase
                end
            end
            CTRL_AN_QUERY, CTRL_AN_SUBSCRIBE: begin
                next_actual = ctrl_event_req_w & `EVT_SUPPORTED;
                next_resp   = (target_present & lun_present) ? `RESP_OK : `RESP_BAD_TARGET;
            end
            default: begin
                next_resp = `RESP_FAILURE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Control sequencing
    // ------------------------------------------------------------
    logic [31:0] ctrl_sub_held;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state             <= ST_IDLE;
            ctrl_done         <= 1'b0;
            ctrl_response     <= 8'h00;
            ctrl_event_actual <= 32'h0000_0000;
            pending_resp      <= 8'h00;
            ctrl_sub_held     <= 32'h0000_0000;
            kill_req          <= 1'b0;
            kill_all          <= 1'b0;
            kill_target_only  <= 1'b0;
            kill_id           <= 64'h0000_0000_0000_0000;
            kill_code         <= 8'h00;
            fence_req         <= 1'b0;
        end else begin
            ctrl_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        pending_resp      <= next_resp;
                        ctrl_event_actual <= actual_le;
                        ctrl_sub_held     <= ctrl_subtype_w;
                        if (needs_kill) begin
                            kill_id          <= ctrl_id;
                            // reset kills whole unit or target
                            kill_all         <= (ctrl_subtype_w != TMF_ABORT_TASK);
                            kill_target_only <= is_nexus;
                            kill_code        <= (ctrl_subtype_w == TMF_ABORT_TASK ||
                                                 ctrl_subtype_w == TMF_ABORT_TASK_SET) ?
                                                `RESP_ABORTED : `RESP_RESET;
                            kill_req         <= 1'b1;
                            state            <= ST_KILL;
                        end else begin
                            state <= ST_FINISH;
                        end
                    end
                end
                ST_KILL: begin
                    if (kill_ack) begin
                        kill_req  <= 1'b0;
                        fence_req <= 1'b1;
                        if (ctrl_sub_held == TMF_ABORT_TASK && !kill_found) begin
                            pending_resp <= `RESP_FUNC_COMPLETE;
                        end else begin
                            pending_resp <= `RESP_FUNC_SUCCEED;
                        end
                        state <= ST_FENCE;
                    end
                end
                ST_FENCE: begin
                    if (fence_ack) begin
                        fence_req <= 1'b0;
                        state     <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    ctrl_response <= pending_resp;
                    ctrl_done     <= 1'b1;
                    state         <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            subscribed <= '0;
        end else if (take && ctrl_type_w == CTRL_AN_SUBSCRIBE && target_present && lun_present) begin
            subscribed[ctrl_lun_sel] <= ctrl_event_req_w & `EVT_SUPPORTED;
        end
    end

    // ------------------------------------------------------------
    // Event queue
    // ------------------------------------------------------------
    logic        missed;
    logic        evt_allowed;
    logic [31:0] evt_reason_f;
    logic        use_buf;
    logic        prompt;

    always_comb begin
        evt_allowed  = 1'b1;
        evt_reason_f = evt_reason;
        case (evt_code)
            EV_TRANSPORT: begin
                if (evt_reason != `REASON_HARD) begin
                    evt_allowed = hotplug_negotiated;
                end
            end
            EV_ASYNC_NOTIFY: begin
                evt_reason_f = evt_reason & subscribed[evt_lun_sel];
                evt_allowed  = (evt_reason_f != 32'h0000_0000);
            end
            EV_PARAM_CHANGE: begin
                evt_allowed  = (evt_dev_type != `MMC_DEV_TYPE);
                evt_reason_f = {16'h0000, evt_reason[15:0]};
            end
            default: begin
                evt_allowed = 1'b0;
            end
        endcase
    end

    assign prompt   = evt_buf_avail & (evt_buf_short | (missed & ~evt_req));
    assign use_buf  = evt_buf_avail & ~evt_buf_short & evt_req & evt_allowed;
    assign evt_taken = evt_req;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            missed <= 1'b0;
        end else if (evt_req && evt_allowed && !use_buf) begin
            missed <= 1'b1;
        end else if (use_buf || prompt) begin
            missed <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            evt_write      <= 1'b0;
            evt_word       <= 32'h0000_0000;
            evt_lun_out    <= 64'h0000_0000_0000_0000;
            evt_reason_out <= 32'h0000_0000;
        end else begin
            evt_write <= use_buf | prompt;
            if (use_buf) begin
                evt_word       <= evt_code | ({31'h0000_0000, missed} << `EVT_MISSED_BIT);
                evt_lun_out    <= evt_lun;
                evt_reason_out <= evt_reason_f;
            end else if (prompt) begin
                evt_word       <= EV_NO_EVENT | ({31'h0000_0000, missed} << `EVT_MISSED_BIT);
                evt_lun_out    <= 64'h0000_0000_0000_0000;
                evt_reason_out <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sense_valid <= 1'b0;
            sense_key   <= 4'h0;
            sense_asc   <= 8'h00;
            sense_ascq  <= 8'h00;
        end else begin
            sense_valid <= evt_req & evt_allowed &
                           (evt_code == EV_TRANSPORT || evt_code == EV_PARAM_CHANGE);
            if (evt_code == EV_PARAM_CHANGE) begin
                sense_key  <= `SENSE_UNIT_ATTN;
                sense_asc  <= evt_reason[7:0];
                sense_ascq <= evt_reason[15:8];
            end else if (evt_reason == `REASON_REMOVED) begin
                sense_key  <= `SENSE_ILLEGAL_REQ;
                sense_asc  <= `ASC_REMOVED;
                sense_ascq <= `ASCQ_ZERO;
            end else if (evt_reason == `REASON_RESCAN) begin
                sense_key  <= `SENSE_UNIT_ATTN;
                sense_asc  <= `ASC_RESCAN;
                sense_ascq <= `ASCQ_RESCAN;
            end else begin
                sense_key  <= `SENSE_UNIT_ATTN;
                sense_asc  <= `ASC_HARD;
                sense_ascq <= `ASCQ_ZERO;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_fence_before_done: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state == ST_FENCE && fence_ack) |=> ##1 ctrl_done)
        else $error("function completed without fence order");
    a_kill_then_fence: assert property (@(posedge ref_clk) disable iff (!nrst)
        (kill_req && kill_ack) |=> fence_req)
        else $error("fence not raised after kills");
    a_missed_bit_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        (use_buf && missed) |=> evt_word[31])
        else $error("missed flag absent");
    a_no_mmc_param: assert property (@(posedge ref_clk) disable iff (!nrst)
        (evt_write && evt_word[30:0] == 31'h0000_0003) |-> $past(evt_dev_type) != `MMC_DEV_TYPE)
        else $error("param change sent for MMC unit");
    a_hotplug_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        (evt_write && evt_word[30:0] == 31'h0000_0001 && evt_reason_out != 32'h0000_0000)
        |-> $past(hotplug_negotiated))
        else $error("hot-plug report without negotiation");
    a_actual_subset: assert property (@(posedge ref_clk) disable iff (!nrst)
        (take && !swap) |=> (ctrl_event_actual & ~`EVT_SUPPORTED) == 32'h0000_0000)
        else $error("unsupported events reported");
    a_reason_subscribed: assert property (@(posedge ref_clk) disable iff (!nrst)
        (use_buf && evt_code == EV_ASYNC_NOTIFY) |=> (evt_reason_out & ~subscribed[$past(evt_lun_sel)]) == 0)
        else $error("unsubscribed event reported");
    a_done_one_cycle: assert property (@(posedge ref_clk) disable iff (!nrst)
        ctrl_done |=> !ctrl_done)
        else $error("done held too long");
    c_tmf_kill: cover property (@(posedge ref_clk) disable iff (!nrst) kill_req ##[1:20] ctrl_done);
    c_evt_missed: cover property (@(posedge ref_clk) disable iff (!nrst) evt_write && evt_word[31]);
    c_subscribe: cover property (@(posedge ref_clk) disable iff (!nrst)
        take && ctrl_type_w == CTRL_AN_SUBSCRIBE);
endmodule

//--- tb/kill_responder.sv
// Far-side model answering kill and fence requests
`timescale 1ns/1ps
module kill_responder (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic slow,
    input  wire logic found,
    input  wire logic kill_req,
    input  wire logic fence_req,
    output logic      kill_ack,
    output logic      kill_found,
    output logic      fence_ack
);
    logic [1:0] cnt;
    // match result only valid with the ack
    assign kill_found = kill_ack ? found : !found;
    // ack kills, then the fence, promptly or slowly
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            {kill_ack, fence_ack, cnt} <= 4'h0;
        end else if ((kill_req || fence_req) && !kill_ack && !fence_ack && (!slow || cnt == 2'h3)) begin
            {kill_ack, fence_ack, cnt} <= {kill_req, fence_req && !kill_req, 2'h0};
        end else begin
            {kill_ack, fence_ack} <= 2'h0;
            cnt <= (kill_req || fence_req) ? cnt + 2'h1 : 2'h0;
        end
    end
endmodule

//--- tb/scsi_ctl_event_tb.sv
// Self-checking bench for the control and event queue handler
`timescale 1ns/1ps
module scsi_ctl_event_tb;
    import scsi_ctl_pkg::*;
    logic         ref_clk, nrst, legacy_mode, guest_big_endian, hotplug_negotiated, ctrl_valid, ctrl_ready;
    logic         ctrl_done, target_present, lun_present, target_busy, kill_req, kill_all, kill_target_only;
    logic         kill_ack, kill_found, fence_req, fence_ack, evt_req, evt_taken, evt_buf_avail, evt_buf_short;
    logic         evt_write, sense_valid, slow, found;
    logic [31:0]  ctrl_type_raw, ctrl_subtype_raw, ctrl_event_req_raw, ctrl_event_actual, evt_reason, evt_word;
    logic [31:0]  evt_reason_out, r;
    logic [63:0]  ctrl_lun, ctrl_id_raw, kill_id, evt_lun, evt_lun_out, lun;
    logic [7:0]   ctrl_response, kill_code, sense_asc, sense_ascq, rs;
    logic [3:0]   sense_key;
    logic [4:0]   evt_dev_type;
    event_code_t  evt_code;
    logic [49:0]  cq[$];
    logic [127:0] eq[$];
    logic [19:0]  sq[$];
    int           fails, num_checks, n;
    scsi_ctl_event scsi_ctl_event_i (.*);
    kill_responder kill_responder_i (.*);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // Checking and driving tasks
    // ----------------------------------------
    task automatic chk(string nm, logic [127:0] seen, logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [31:0] sw(logic [31:0] x);
        return {<<8{x}};
    endfunction
    task automatic ctl(logic [31:0] ty, sb, rq, act, logic [7:0] rsp, kc, logic ka, ca);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (ctrl_ready !== 1'b1 && n < 100);
        if (ctrl_ready !== 1'b1) begin
            fails++;
            final_report();
        end
        {ctrl_type_raw, ctrl_subtype_raw, ctrl_event_req_raw} = {ty, sb, rq};
        {ctrl_lun, ctrl_id_raw, ctrl_valid} = {lun, 32'h0000_0000, $urandom, 1'b1};
        cq.push_back({ca, rsp, act, kc, ka});
        @(negedge ref_clk);
        ctrl_valid = 1'b0;
    endtask
    task automatic ev(event_code_t c, logic [31:0] rn, logic [4:0] dt, logic ba, logic [127:0] e, logic [19:0] s);
        @(negedge ref_clk);
        {evt_req, evt_buf_avail, evt_reason, evt_dev_type, evt_lun} = {1'b1, ba, rn, dt, lun};
        evt_code = c;
        if (e !== 128'h0) eq.push_back(e);
        if (s !== 20'h0) sq.push_back(s);
        @(negedge ref_clk);
        evt_req = 1'b0;
    endtask
    // ----------------------------------------
    // Output monitor
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (nrst === 1'b1 && kill_req === 1'b1 && kill_ack === 1'b1) begin
            chk("kill_code", kill_code, cq[0][8:1]);
            chk("kill_all", kill_all, cq[0][0]);
            chk("kill_id", kill_id, ctrl_id_raw);
            chk("kill_target_only", kill_target_only, ctrl_subtype_raw == 32'h0000_0004);
        end
        if (nrst === 1'b1 && ctrl_done === 1'b1) begin
            chk("ctrl_response", ctrl_response, cq[0][48:41]);
            if (cq[0][49]) chk("ctrl_event_actual", ctrl_event_actual, cq[0][40:9]);
            void'(cq.pop_front());
        end
        if (nrst === 1'b1 && evt_req === 1'b1) chk("evt_taken", evt_taken, 1'b1);
        if (nrst === 1'b1 && evt_write === 1'b1) begin
            chk("evt_word", evt_word, eq[0][127:96]);
            if (eq[0][97:96] != 2'h0) chk("evt_body", {evt_lun_out, evt_reason_out}, eq[0][95:0]);
            void'(eq.pop_front());
        end
        if (nrst === 1'b1 && sense_valid === 1'b1) begin
            chk("sense", {sense_key, sense_asc, sense_ascq}, sq[0]);
            void'(sq.pop_front());
        end
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        {nrst, legacy_mode, guest_big_endian, hotplug_negotiated, ctrl_valid, target_busy, slow, evt_req} = 8'h00;
        {target_present, lun_present, found, evt_buf_avail, evt_buf_short} = 5'h1e;
        {ctrl_type_raw, ctrl_subtype_raw, ctrl_event_req_raw, ctrl_lun, ctrl_id_raw, evt_lun, evt_reason} = '0;
        evt_dev_type = 5'h00;
        evt_code = EV_NO_EVENT;
        lun = 64'h0100_0000_0001_0000;
        n = $urandom(94044);
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1'b1;
        for (int i = 0; i < 3; i++) begin
            r = $urandom;
            ctl(CTRL_AN_QUERY, 0, r, r & 32'h0000_007e, 8'h00, 8'h00, 0, 1);
        end
        ctl(CTRL_AN_SUBSCRIBE, 0, 32'h0000_0092, 32'h0000_0012, 8'h00, 8'h00, 0, 1);
        ctl(32'h0000_0005, 0, 0, 0, 8'h09, 8'h00, 0, 0);
        $display("test query and subscribe done");
        for (int s = 0; s < 9; s++) begin
            slow = s[0];
            rs = (s == 8) ? 8'h0b : (s inside {2, 3, 6, 7}) ? 8'h00 : 8'h0a;
            ctl(CTRL_TMF, s, 0, 0, rs, (s < 2) ? 8'h02 : 8'h04, s != 0, 0);
        end
        found = 1'b0;
        ctl(CTRL_TMF, 0, 0, 0, 8'h00, 8'h02, 0, 0);
        target_busy = 1'b1;
        ctl(CTRL_TMF, 5, 0, 0, 8'h05, 8'h04, 1, 0);
        {target_busy, target_present} = 2'h0;
        ctl(CTRL_TMF, 5, 0, 0, 8'h03, 8'h04, 1, 0);
        {target_present, lun_present} = 2'h2;
        ctl(CTRL_TMF, 5, 0, 0, 8'h0c, 8'h04, 1, 0);
        ctl(CTRL_TMF, 4, 0, 0, 8'h0a, 8'h04, 1, 0);
        lun_present = 1'b1;
        $display("test task management done");
        {legacy_mode, guest_big_endian} = 2'h3;
        r = $urandom;
        ctl(sw(32'h0000_0001), 0, sw(r), sw(r & 32'h0000_007e), 8'h00, 8'h00, 0, 1);
        {legacy_mode, guest_big_endian} = 2'h0;
        $display("test legacy order done");
        ev(EV_TRANSPORT, 32'h0000_0000, 5'h00, 1, {32'h0000_0001, lun, 32'h0000_0000}, 20'h6_2900);
        ev(EV_TRANSPORT, 32'h0000_0001, 5'h00, 1, 128'h0, 20'h0);
        hotplug_negotiated = 1'b1;
        ev(EV_TRANSPORT, 32'h0000_0001, 5'h00, 1, {32'h0000_0001, lun, 32'h0000_0001}, 20'h6_3f0e);
        ev(EV_TRANSPORT, 32'h0000_0002, 5'h00, 1, {32'h0000_0001, lun, 32'h0000_0002}, 20'h5_2500);
        ev(EV_ASYNC_NOTIFY, 32'h0000_00f6, 5'h00, 1, {32'h0000_0002, lun, 32'h0000_0012}, 20'h0);
        ev(EV_PARAM_CHANGE, 32'hab12_0e2a, 5'h05, 1, 128'h0, 20'h0);
        ev(EV_PARAM_CHANGE, 32'hab12_0e2a, 5'h00, 1, {32'h0000_0003, lun, 32'h0000_0e2a}, 20'h6_2a0e);
        ev(EV_ASYNC_NOTIFY, 32'h0000_0010, 5'h00, 0, 128'h0, 20'h0);
        ev(EV_TRANSPORT, 32'h0000_0000, 5'h00, 1, {32'h8000_0001, lun, 32'h0000_0000}, 20'h6_2900);
        ev(EV_ASYNC_NOTIFY, 32'h0000_0010, 5'h00, 0, 128'h0, 20'h0);
        eq.push_back({32'h8000_0000, 96'h0});
        evt_buf_avail = 1'b1;
        repeat (3) @(negedge ref_clk);
        eq.push_back(128'h0);
        evt_buf_short = 1'b1;
        @(negedge ref_clk);
        evt_buf_short = 1'b0;
        repeat (10) @(negedge ref_clk);
        $display("test event queue done");
        chk("queues empty", cq.size() + eq.size() + sq.size(), 0);
        final_report();
    end
endmodule
